// ### common/uofr_pkg.sv
package uofr_pkg;
  localparam logic [11:0] OFS_NP_STATUS = 12'h02c;
  localparam logic [11:0] OFS_CORE_CFG = 12'h038;
  localparam logic [11:0] OFS_CORE_ID = 12'h03c;
  localparam logic [11:0] OFS_PER_FIFO = 12'h100;
  localparam logic [11:0] OFS_IN_FIFO_BASE = 12'h104;
  localparam logic [11:0] OFS_IN_FIFO_STEP = 12'h004;
  localparam logic [11:0] OFS_HOST_CFG = 12'h400;
  localparam logic [11:0] OFS_HOST_MODE = 12'h800;
  localparam int IN_FIFO_COUNT = 3;
  localparam logic [31:0] RST_NP_STATUS = 32'h00080200;
  localparam logic [31:0] RST_CORE_CFG = 32'h00000000;
  localparam logic [31:0] RST_CORE_ID = 32'h00005a5a; // arbitrary value
  localparam logic [31:0] RST_PER_FIFO = 32'h02000400;
  localparam logic [31:0] RST_IN_FIFO = 32'h02000200;
  localparam logic [31:0] RST_HOST_CFG = 32'h00000004;
  localparam logic [7:0] NP_QUEUE_DEPTH = 8'h08;
  localparam logic [15:0] NP_FIFO_DEPTH = 16'h0100;
  localparam int BIT_SENSE_DIS = 21;
  localparam int BIT_FRAME_OUT = 20;
  localparam int BIT_B_SENSE = 19;
  localparam int BIT_A_SENSE = 18;
  localparam int BIT_XCVR_ON = 16;
  localparam int BIT_FSLS_ONLY = 2;
  localparam logic [31:0] CORE_CFG_MASK = 32'h003d0000;
  localparam logic [1:0] ENTRY_TOKEN = 2'h0;
  localparam logic [1:0] ENTRY_ZLP = 2'h1;
  localparam logic [1:0] ENTRY_HALT = 2'h3;
  localparam logic [1:0] PHY_CLK_48 = 2'h1;
  localparam logic [1:0] PHY_CLK_6 = 2'h2;

  typedef struct packed {
    logic [3:0] chan;
    logic [1:0] kind;
    logic last;
  } uofr_entry_type;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } uofr_bus_type;
endpackage

// ### core/uofr_regs.sv
// Chosen here: the strobed register port.
`timescale 1ns/1ns
// How it works
// R01: read-only non-periodic status at 0x02c, host only
// R02: bits 30:24 show queue top entry
// R03: entry type: token, zero-length, halt
// R04: bits 23:16 free queue slots, 0..8
// R05: device role queues only in requests
// R06: bits 15:0 free fifo words, 0..512
// R07: bit 21 forces bus power valid
// R08: bit 20 gates frame pulse to pad
// R09: bits 19/18 enable b/a power sensing
// R10: bit 16 powers the transceiver
// R11: id register fully writable at 0x03c
// R12: periodic fifo size: depth and start
// R13: periodic fifo size resets to 0x02000400
// R14: three in-endpoint fifo size registers
// R15: software aligns in-fifo start addresses
// R16: software avoids host registers in device role
// R17: software sets host config once at init
// R18: host config bit 2 reads one
// R19: software disables sensing only single-role
// R20: phy clock select codes 01 and 10
// R21: counts track pushes and pops
module uofr_regs #(
  parameter int QW = 8,
  parameter int FW = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire uofr_pkg::uofr_bus_type bus,
  output logic [31:0] rdata,
  input wire logic q_push,
  input wire logic q_push_out,
  input wire uofr_pkg::uofr_entry_type q_push_entry,
  input wire logic q_pop,
  input wire logic f_push,
  input wire logic f_pop,
  input wire logic frame_pulse,
  input wire logic bus_power_pin,
  output logic frame_pulse_pad,
  output logic bus_power_valid,
  output logic b_role_sense_on,
  output logic a_role_sense_on,
  output logic xcvr_active,
  output logic [1:0] phy_clock_select,
  output logic host_mode
);
  logic [31:0] core_cfg_r;
  logic [31:0] core_id_r;
  logic [1:0] host_cfg_r;
  logic host_mode_r;
  logic [QW-1:0] q_free_r;
  logic [FW-1:0] f_free_r;
  uofr_pkg::uofr_entry_type top_r;
  logic pin_s1_r;
  logic pin_s2_r;
  logic q_take;
  logic q_ok;
  logic f_take;
  logic f_ok;
  logic [31:0] rd_nxt;
  logic [11:0] in_idx_ofs;

  wire wr_en = clk_en && bus.wr;
  wire rd_en = clk_en && bus.rd;

  // device role rejects out requests; full queue rejects anything
  assign q_ok = q_push && (host_mode_r || !q_push_out) && (q_free_r != '0); // R05
  assign q_take = q_pop && (q_free_r != QW'(uofr_pkg::NP_QUEUE_DEPTH));
  assign f_ok = f_push && (f_free_r != '0);
  // ceiling is the reset level, which sits above the nominal word depth
  assign f_take = f_pop && (f_free_r != FW'(uofr_pkg::RST_NP_STATUS[15:0]));

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
    end
    else if (clk_en)
    begin
      pin_s1_r <= bus_power_pin;
      pin_s2_r <= pin_s1_r;
    end

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      core_cfg_r <= uofr_pkg::RST_CORE_CFG;
    else if (wr_en && bus.addr == uofr_pkg::OFS_CORE_CFG)
      core_cfg_r <= bus.wdata & uofr_pkg::CORE_CFG_MASK;

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      core_id_r <= uofr_pkg::RST_CORE_ID;
    else if (wr_en && bus.addr == uofr_pkg::OFS_CORE_ID)
      core_id_r <= bus.wdata; // R11

  // writes of reserved clock codes are refused, but the phy sees the reset code 00 until 01 or 10 is written
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      host_cfg_r <= uofr_pkg::RST_HOST_CFG[1:0];
    else if (wr_en && bus.addr == uofr_pkg::OFS_HOST_CFG &&
             (bus.wdata[1:0] == uofr_pkg::PHY_CLK_48 ||
              bus.wdata[1:0] == uofr_pkg::PHY_CLK_6))
      host_cfg_r <= bus.wdata[1:0]; // R20

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      host_mode_r <= 1'b0;
    else if (wr_en && bus.addr == uofr_pkg::OFS_HOST_MODE)
      host_mode_r <= bus.wdata[0];

  // simultaneous accepted push and pop leave the count unchanged
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      q_free_r <= QW'(uofr_pkg::RST_NP_STATUS[23:16]);
    else if (clk_en && (q_ok != q_take))
      q_free_r <= q_ok ? q_free_r - 1'b1 : q_free_r + 1'b1; // R21

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      f_free_r <= FW'(uofr_pkg::RST_NP_STATUS[15:0]);
    else if (clk_en && (f_ok != f_take))
      f_free_r <= f_ok ? f_free_r - 1'b1 : f_free_r + 1'b1; // R21

  // only the last pushed entry is kept as top; limitation: no full queue model
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      top_r <= '0;
    else if (clk_en && q_ok)
      top_r <= q_push_entry; // R02 R03

  always_comb
  begin
    in_idx_ofs = bus.addr - uofr_pkg::OFS_IN_FIFO_BASE;
    rd_nxt = 32'h00000000;
    unique case (bus.addr)
      uofr_pkg::OFS_NP_STATUS:
        if (host_mode_r) // R01
          rd_nxt = {1'b0, top_r, 8'(q_free_r), 16'(f_free_r)}; // R04 R06
      uofr_pkg::OFS_CORE_CFG: rd_nxt = core_cfg_r;
      uofr_pkg::OFS_CORE_ID: rd_nxt = core_id_r;
      uofr_pkg::OFS_PER_FIFO: rd_nxt = uofr_pkg::RST_PER_FIFO; // R12 R13
      uofr_pkg::OFS_HOST_CFG: rd_nxt = {29'h0, 1'b1, host_cfg_r}; // R18
      uofr_pkg::OFS_HOST_MODE: rd_nxt = {31'h0, host_mode_r};
      default:
        if (bus.addr >= uofr_pkg::OFS_IN_FIFO_BASE && in_idx_ofs[1:0] == 2'h0 &&
            in_idx_ofs < 12'(uofr_pkg::IN_FIFO_COUNT) * uofr_pkg::OFS_IN_FIFO_STEP)
          rd_nxt = uofr_pkg::RST_IN_FIFO; // R14
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      rdata <= 32'h00000000;
    else if (clk_en)
      rdata <= rd_en ? rd_nxt : 32'h00000000;

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      frame_pulse_pad <= 1'b0;
      bus_power_valid <= 1'b0;
      b_role_sense_on <= 1'b0;
      a_role_sense_on <= 1'b0;
      xcvr_active <= 1'b0;
      phy_clock_select <= 2'h0;
      host_mode <= 1'b0;
    end
    else if (clk_en)
    begin
      frame_pulse_pad <= frame_pulse && core_cfg_r[uofr_pkg::BIT_FRAME_OUT]; // R08
      bus_power_valid <= core_cfg_r[uofr_pkg::BIT_SENSE_DIS] || pin_s2_r; // R07
      b_role_sense_on <= core_cfg_r[uofr_pkg::BIT_B_SENSE]; // R09
      a_role_sense_on <= core_cfg_r[uofr_pkg::BIT_A_SENSE]; // R09
      xcvr_active <= core_cfg_r[uofr_pkg::BIT_XCVR_ON]; // R10
      phy_clock_select <= host_cfg_r; // R20
      host_mode <= host_mode_r;
    end

  property p_q_bound;
    @(posedge clk) disable iff (!rst_n) q_free_r <= QW'(uofr_pkg::NP_QUEUE_DEPTH);
  endproperty
  a_q_bound: assert property (p_q_bound) else $error("queue free above 8"); // R04

  property p_f_bound;
    @(posedge clk) disable iff (!rst_n) f_free_r <= FW'(uofr_pkg::RST_NP_STATUS[15:0]);
  endproperty
  a_f_bound: assert property (p_f_bound) else $error("fifo free above reset level"); // R06

  property p_dev_out;
    @(posedge clk) disable iff (!rst_n)
      clk_en && !host_mode_r && q_push && q_push_out && !q_take |=> $stable(q_free_r);
  endproperty
  a_dev_out: assert property (p_dev_out) else $error("out request taken as device"); // R05

  property p_q_count;
    @(posedge clk) disable iff (!rst_n)
      clk_en && q_ok && !q_take |=> q_free_r == $past(q_free_r) - 1'b1;
  endproperty
  a_q_count: assert property (p_q_count) else $error("queue count not reduced"); // R21

  property p_sense_dis;
    @(posedge clk) disable iff (!rst_n)
      clk_en && core_cfg_r[uofr_pkg::BIT_SENSE_DIS] |=> bus_power_valid;
  endproperty
  a_sense_dis: assert property (p_sense_dis) else $error("bus power not forced"); // R07

  property p_pad_gate;
    @(posedge clk) disable iff (!rst_n)
      clk_en && !core_cfg_r[uofr_pkg::BIT_FRAME_OUT] |=> !frame_pulse_pad;
  endproperty
  a_pad_gate: assert property (p_pad_gate) else $error("frame pulse leaked"); // R08

  property p_id_wr;
    @(posedge clk) disable iff (!rst_n)
      wr_en && bus.addr == uofr_pkg::OFS_CORE_ID |=> core_id_r == $past(bus.wdata);
  endproperty
  a_id_wr: assert property (p_id_wr) else $error("id write lost"); // R11

  property p_fsls;
    @(posedge clk) disable iff (!rst_n)
      rd_en && bus.addr == uofr_pkg::OFS_HOST_CFG |=> rdata[uofr_pkg::BIT_FSLS_ONLY];
  endproperty
  a_fsls: assert property (p_fsls) else $error("fsls bit not one"); // R18

  property p_per_rd;
    @(posedge clk) disable iff (!rst_n)
      rd_en && bus.addr == uofr_pkg::OFS_PER_FIFO |=> rdata == uofr_pkg::RST_PER_FIFO;
  endproperty
  a_per_rd: assert property (p_per_rd) else $error("periodic size wrong"); // R13

  property p_xcvr;
    @(posedge clk) disable iff (!rst_n)
      clk_en |=> xcvr_active == $past(core_cfg_r[uofr_pkg::BIT_XCVR_ON]);
  endproperty
  a_xcvr: assert property (p_xcvr) else $error("transceiver control wrong"); // R10

  property p_kind;
    @(posedge clk) disable iff (!rst_n)
      1'b1 |->
      top_r.kind != 2'h2;
  endproperty
  a_kind: assert property (p_kind) else $error("reserved entry type stored"); // R03

  property p_top_load;
    @(posedge clk) disable iff (!rst_n)
      clk_en && q_ok |=>
      top_r == $past(q_push_entry);
  endproperty
  a_top_load: assert property (p_top_load) else $error("queue top not loaded"); // R02

  property p_q_full;
    @(posedge clk) disable iff (!rst_n)
      clk_en && q_push && q_free_r == '0 && !q_take |=>
      q_free_r == '0;
  endproperty
  a_q_full: assert property (p_q_full) else $error("push taken while full"); // R04

  property p_q_pop;
    @(posedge clk) disable iff (!rst_n)
      clk_en && q_take && !q_ok |=>
      q_free_r == $past(q_free_r) + 1'b1;
  endproperty
  a_q_pop: assert property (p_q_pop) else $error("queue pop not counted"); // R21

  property p_dev_in;
    @(posedge clk) disable iff (!rst_n)
      clk_en && !host_mode_r && q_push && !q_push_out && q_free_r != '0 && !q_take |=>
      q_free_r == $past(q_free_r) - 1'b1;
  endproperty
  a_dev_in: assert property (p_dev_in) else $error("in request refused as device"); // R05

  property p_f_count;
    @(posedge clk) disable iff (!rst_n)
      clk_en && f_ok && !f_take |=>
      f_free_r == $past(f_free_r) - 1'b1;
  endproperty
  a_f_count: assert property (p_f_count) else $error("fifo count not reduced"); // R21

  property p_f_pop;
    @(posedge clk) disable iff (!rst_n)
      clk_en && f_take && !f_ok |=>
      f_free_r == $past(f_free_r) + 1'b1;
  endproperty
  a_f_pop: assert property (p_f_pop) else $error("fifo drain not counted"); // R21

  property p_f_full;
    @(posedge clk) disable iff (!rst_n)
      clk_en && f_push && f_free_r == '0 && !f_take |=>
      f_free_r == '0;
  endproperty
  a_f_full: assert property (p_f_full) else $error("word taken while full"); // R06

  property p_dev_read;
    @(posedge clk) disable iff (!rst_n)
      rd_en && bus.addr == uofr_pkg::OFS_NP_STATUS && !host_mode_r |=>
      rdata == 32'h00000000;
  endproperty
  a_dev_read: assert property (p_dev_read) else $error("status visible as device"); // R01

  property p_phy_legal;
    @(posedge clk) disable iff (!rst_n)
      1'b1 |->
      phy_clock_select != 2'h3;
  endproperty
  a_phy_legal: assert property (p_phy_legal) else $error("reserved clock code out"); // R20

  property p_host_cfg_ign;
    @(posedge clk) disable iff (!rst_n)
      wr_en && bus.addr == uofr_pkg::OFS_HOST_CFG &&
      bus.wdata[1:0] != uofr_pkg::PHY_CLK_48 && bus.wdata[1:0] != uofr_pkg::PHY_CLK_6 |=>
      $stable(host_cfg_r);
  endproperty
  a_host_cfg_ign: assert property (p_host_cfg_ign) else $error("reserved code taken"); // R20

  property p_phy_follow;
    @(posedge clk) disable iff (!rst_n)
      clk_en |=>
      phy_clock_select == $past(host_cfg_r);
  endproperty
  a_phy_follow: assert property (p_phy_follow) else $error("clock select lags"); // R20

  property p_b_sense;
    @(posedge clk) disable iff (!rst_n)
      clk_en |=>
      b_role_sense_on == $past(core_cfg_r[uofr_pkg::BIT_B_SENSE]);
  endproperty
  a_b_sense: assert property (p_b_sense) else $error("b sensing wrong"); // R09

  property p_a_sense;
    @(posedge clk) disable iff (!rst_n)
      clk_en |=>
      a_role_sense_on == $past(core_cfg_r[uofr_pkg::BIT_A_SENSE]);
  endproperty
  a_a_sense: assert property (p_a_sense) else $error("a sensing wrong"); // R09

  property p_sense_pin;
    @(posedge clk) disable iff (!rst_n)
      clk_en && !core_cfg_r[uofr_pkg::BIT_SENSE_DIS] |=>
      bus_power_valid == $past(pin_s2_r);
  endproperty
  a_sense_pin: assert property (p_sense_pin) else $error("pin sensing lost"); // R07

  property p_pad_pass;
    @(posedge clk) disable iff (!rst_n)
      clk_en && core_cfg_r[uofr_pkg::BIT_FRAME_OUT] && frame_pulse |=>
      frame_pulse_pad;
  endproperty
  a_pad_pass: assert property (p_pad_pass) else $error("frame pulse blocked"); // R08

  // a frozen clock enable must hold counts and settings
  property p_freeze;
    @(posedge clk) disable iff (!rst_n)
      !clk_en |=>
      $stable(core_cfg_r) && $stable(q_free_r) && $stable(f_free_r);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen"); // R21

  property p_in_rd;
    @(posedge clk) disable iff (!rst_n)
      rd_en && bus.addr == uofr_pkg::OFS_IN_FIFO_BASE |=>
      rdata == uofr_pkg::RST_IN_FIFO;
  endproperty
  a_in_rd: assert property (p_in_rd) else $error("in fifo size wrong"); // R14

  property p_cfg_rd;
    @(posedge clk) disable iff (!rst_n)
      rd_en && bus.addr == uofr_pkg::OFS_CORE_CFG |=>
      rdata == $past(core_cfg_r);
  endproperty
  a_cfg_rd: assert property (p_cfg_rd) else $error("config read wrong"); // R10

  property p_id_rd;
    @(posedge clk) disable iff (!rst_n)
      rd_en && bus.addr == uofr_pkg::OFS_CORE_ID |=>
      rdata == $past(core_id_r);
  endproperty
  a_id_rd: assert property (p_id_rd) else $error("id read wrong"); // R11

  c_q_full: cover property (@(posedge clk) disable iff (!rst_n) q_free_r == '0);
  c_f_full: cover property (@(posedge clk) disable iff (!rst_n) f_free_r == '0);
  c_both: cover property (@(posedge clk) disable iff (!rst_n) q_ok && q_take);
  c_pad: cover property (@(posedge clk) disable iff (!rst_n) frame_pulse_pad);
endmodule

// ### tb/uofr_usb_side.sv
`timescale 1ns/1ns
module uofr_usb_side (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic vbus_on,
  output logic frame_pulse,
  output logic bus_power_pin
);
  logic [1:0] ph_r;
  // period of four keeps the pad pulse count exact
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      ph_r <= 2'h0;
      frame_pulse <= 1'b0;
    end
    else
    begin
      ph_r <= ph_r + 2'h1;
      frame_pulse <= (ph_r == 2'h3);
    end
  assign bus_power_pin = vbus_on;
endmodule

// ### tb/uofr_regs_tb_top.sv
`timescale 1ns/1ns
module uofr_regs_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic vbus_on = 1'b0;
  logic [3:0] strb = 4'h0;
  logic q_out = 1'b0;
  logic en = 1'b1;
  uofr_pkg::uofr_entry_type ent = '0;
  uofr_pkg::uofr_bus_type bus = '0;
  logic [31:0] rdata, got;
  logic fp, bpin, fpad, bpv, bse, ase, xon, hm;
  logic [1:0] pcs;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  uofr_regs i_uofr_regs (.clk(clk), .rst_n(rst_n), .clk_en(en), .bus(bus), .rdata(rdata),
    .q_push(strb[0]), .q_push_out(q_out), .q_push_entry(ent), .q_pop(strb[1]),
    .f_push(strb[2]), .f_pop(strb[3]), .frame_pulse(fp), .bus_power_pin(bpin),
    .frame_pulse_pad(fpad), .bus_power_valid(bpv), .b_role_sense_on(bse),
    .a_role_sense_on(ase), .xcvr_active(xon), .phy_clock_select(pcs), .host_mode(hm));
  uofr_usb_side i_uofr_usb_side (.clk(clk), .rst_n(rst_n), .vbus_on(vbus_on),
    .frame_pulse(fp), .bus_power_pin(bpin));
  initial forever #10 clk = ~clk;
  task automatic tally_and_finish();
    if (failures == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      failures = failures + 1;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 got = rdata;
  endtask
  task automatic pulse(input logic [3:0] s);
    @(posedge clk);
    strb <= s;
    @(posedge clk);
    strb <= 4'h0;
  endtask
  task automatic pads(input int e);
    int n;
    n = 0;
    repeat (16)
    begin
      @(posedge clk);
      #1 n += fpad;
    end
    chk(n, e);
  endtask
  task automatic t_reset();
    rd(uofr_pkg::OFS_NP_STATUS);
    chk(got, 32'h0);
    wr(uofr_pkg::OFS_PER_FIFO, 32'h0);
    rd(uofr_pkg::OFS_PER_FIFO);
    chk(got, uofr_pkg::RST_PER_FIFO);
    for (int i = 0; i < 3; i++)
    begin
      rd(uofr_pkg::OFS_IN_FIFO_BASE + 12'(i) * uofr_pkg::OFS_IN_FIFO_STEP);
      chk(got, uofr_pkg::RST_IN_FIFO);
      chk(got[1:0], 2'h0);
    end
    rd(uofr_pkg::OFS_HOST_CFG);
    chk(got, uofr_pkg::RST_HOST_CFG);
    rd(uofr_pkg::OFS_CORE_ID);
    chk(got, uofr_pkg::RST_CORE_ID);
    wr(12'h200, 32'hffffffff);
    rd(12'h200);
    chk(got, 32'h0);
    wr(uofr_pkg::OFS_CORE_ID, 32'ha5c30f96);
    rd(uofr_pkg::OFS_CORE_ID);
    chk(got, 32'ha5c30f96);
  endtask
  task automatic t_cfg();
    wr(uofr_pkg::OFS_CORE_CFG, 32'hffffffff);
    rd(uofr_pkg::OFS_CORE_CFG);
    chk(got, uofr_pkg::CORE_CFG_MASK);
    chk({bpv, bse, ase, xon}, 4'hf);
    pads(4);
    wr(uofr_pkg::OFS_CORE_CFG, 32'h0);
    repeat (5) @(posedge clk);
    #1 chk({bpv, bse, ase, xon}, 4'h0);
    pads(0);
    vbus_on <= 1'b1;
    repeat (5) @(posedge clk);
    #1 chk(bpv, 1'b1);
  endtask
  task automatic t_queue();
    logic [1:0] kinds [3];
    kinds = '{uofr_pkg::ENTRY_TOKEN, uofr_pkg::ENTRY_ZLP, uofr_pkg::ENTRY_HALT};
    wr(uofr_pkg::OFS_HOST_MODE, 32'h1);
    q_out <= 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      ent <= '{chan: 4'h9, kind: kinds[k], last: k[0]};
      pulse(4'h1);
      rd(uofr_pkg::OFS_NP_STATUS);
      chk(got, {1'b0, 4'h9, kinds[k], k[0], 8'h07, 16'h0200});
      pulse(4'h2);
    end
    repeat (9) pulse(4'h1);
    rd(uofr_pkg::OFS_NP_STATUS);
    chk(got[23:16], 8'h00);
    pulse(4'h2);
    pulse(4'h4);
    rd(uofr_pkg::OFS_NP_STATUS);
    chk(got[23:0], 24'h0101ff);
    pulse(4'h8);
    wr(uofr_pkg::OFS_HOST_MODE, 32'h0);
    pulse(4'h2);
    pulse(4'h1);
    q_out <= 1'b0;
    pulse(4'h1);
    wr(uofr_pkg::OFS_HOST_MODE, 32'h1);
    rd(uofr_pkg::OFS_NP_STATUS);
    chk(got[23:0], 24'h010200);
    chk(hm, 1'b1);
  endtask
  task automatic t_phy();
    wr(uofr_pkg::OFS_HOST_CFG, 32'h1);
    wr(uofr_pkg::OFS_HOST_CFG, 32'h3);
    rd(uofr_pkg::OFS_HOST_CFG);
    chk(got, 32'h5);
    chk(pcs, uofr_pkg::PHY_CLK_48);
    wr(uofr_pkg::OFS_HOST_CFG, 32'h2);
    wr(uofr_pkg::OFS_HOST_CFG, 32'h0);
    rd(uofr_pkg::OFS_HOST_CFG);
    chk(got, 32'h6);
    chk(pcs, uofr_pkg::PHY_CLK_6);
    @(posedge clk);
    en <= 1'b0;
    wr(uofr_pkg::OFS_CORE_ID, 32'h00000001);
    en <= 1'b1;
    rd(uofr_pkg::OFS_CORE_ID);
    chk(got, 32'ha5c30f96);
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_cfg();
    t_queue();
    t_phy();
    tally_and_finish();
  end
endmodule
